// File: hw/ascii_rx_map.vh
// Register offsets, field positions, constants and timing counts for the ASCII receiver
`ifndef ASCII_RX_MAP_VH
`define ASCII_RX_MAP_VH

// ==========================================================================
// Register byte offsets
`define REG_CTRL        12'h000
`define REG_CFG         12'h004
`define REG_TIMEOUT     12'h008
`define REG_STATUS      12'h00C
`define REG_IRQ_STAT    12'h010
`define REG_IRQ_MASK    12'h014
`define REG_COUNT       12'h018

// ==========================================================================
// Control fields
`define CTRL_ENABLE     0
`define CTRL_NETCMD     1
`define CTRL_MODE_TX    2

// Config fields
`define CFG_LEN_LSB     0
`define CFG_LEN_MSB     7
`define CFG_SWAP        8
`define CFG_PORT_LSB    12
`define CFG_PORT_MSB    15
`define CFG_DEST_LSB    16
`define CFG_DEST_MSB    31

// Timeout fields in milliseconds
`define TO_IC_LSB       0
`define TO_IC_MSB       15
`define TO_FC_LSB       16
`define TO_FC_MSB       31

// Status bits
`define ST_BUSY         0
`define ST_DONE         1
`define ST_IC_ERR       2
`define ST_FC_ERR       3
`define ST_PORT_BUSY    4
`define ST_COMM_ERR     5
`define ST_CANNOT       6
`define ST_INVALID      7

// Interrupt event bits
`define EV_DONE         0
`define EV_IC_ERR       1
`define EV_FC_ERR       2
`define EV_COMM_ERR     3
`define EV_FAULT        4

// ==========================================================================
// Constants and timing
`define PORT_TWO        4'h2
`define MAX_LEN         8'h80
`define CLK_HZ          10000000
`define MS_PER_SEC      1000
`define MS_CYCLES       (`CLK_HZ / `MS_PER_SEC)

`endif

// File: hw/ascii_fixed_length_receiver.v
// Fixed-length raw ASCII receiver with APB registers and word-memory writer
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ascii_rx_map.vh"

module ascii_fixed_length_receiver
#(
    parameter MS_CYC = `MS_CYCLES
)
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        rx_error,
    output reg         mem_we,
    output reg  [15:0] mem_addr,
    output reg  [15:0] mem_wdata,
    output reg         irq
);

    // ======================================================================
    // States
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_WAIT = 2'd1;
    localparam [1:0] S_RECV = 2'd2;
    localparam [1:0] S_DONE = 2'd3;

    reg  [2:0]  ctrl_ff;
    reg  [31:0] cfg_ff;
    reg  [31:0] tmo_ff;
    reg  [4:0]  irq_stat_ff;
    reg  [4:0]  irq_mask_ff;
    reg  [1:0]  state_ff;
    reg  [7:0]  cnt_ff;
    reg  [15:0] ms_ff;
    reg  [31:0] tick_ff;
    reg         done_ff;
    reg         ic_err_ff;
    reg         fc_err_ff;
    reg         comm_err_ff;
    reg         cannot_ff;
    reg         invalid_ff;
    reg         wr_busy_ff;
    reg  [7:0]  wr_idx_ff;
    reg  [7:0]  buf_ff [0:127];
    reg         vld_s1_ff;
    reg         vld_s2_ff;
    reg         vld_s3_ff;
    reg         err_s1_ff;
    reg         err_s2_ff;
    reg  [7:0]  dat_s1_ff;
    reg  [7:0]  dat_s2_ff;

    wire [7:0]  cfg_len  = cfg_ff[`CFG_LEN_MSB:`CFG_LEN_LSB];
    wire        cfg_swap = cfg_ff[`CFG_SWAP];
    wire [3:0]  cfg_port = cfg_ff[`CFG_PORT_MSB:`CFG_PORT_LSB];
    wire [15:0] cfg_dest = cfg_ff[`CFG_DEST_MSB:`CFG_DEST_LSB];
    wire [15:0] ic_lim   = tmo_ff[`TO_IC_MSB:`TO_IC_LSB];
    wire [15:0] fc_lim   = tmo_ff[`TO_FC_MSB:`TO_FC_LSB];
    wire        enable   = ctrl_ff[`CTRL_ENABLE];

    // Zero length or above 128 is out of range
    wire        len_bad  = (cfg_len == 8'h00) || (cfg_len > `MAX_LEN);
    // Wrong port or port owned by transmit side
    wire        no_exec  = (cfg_port != `PORT_TWO) || ctrl_ff[`CTRL_MODE_TX];

    wire        apb_wr   = psel && penable && pwrite;
    wire        apb_rd   = psel && !penable && !pwrite;
    wire        rx_stb   = vld_s2_ff && !vld_s3_ff;
    wire        ms_tick  = (tick_ff == MS_CYC - 1);
    wire        busy     = (state_ff == S_RECV) || wr_busy_ff;

    // ======================================================================
    // Zero-wait slave, never errors; kept in flops so every output is
    // registered, at the cost of two constant flops
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
    end

    // ======================================================================
    // Pin synchronisers; data is stable around the valid level
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vld_s1_ff <= 1'b0;
            vld_s2_ff <= 1'b0;
            vld_s3_ff <= 1'b0;
            err_s1_ff <= 1'b0;
            err_s2_ff <= 1'b0;
            dat_s1_ff <= 8'h00;
            dat_s2_ff <= 8'h00;
        end
        else
        begin
            vld_s1_ff <= rx_valid;
            vld_s2_ff <= vld_s1_ff;
            vld_s3_ff <= vld_s2_ff;
            err_s1_ff <= rx_error;
            err_s2_ff <= err_s1_ff;
            dat_s1_ff <= rx_data;
            dat_s2_ff <= dat_s1_ff;
        end
    end

    // ======================================================================
    // Millisecond prescaler
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_ff <= 32'h0000_0000;
        else if (ms_tick)
            tick_ff <= 32'h0000_0000;
        else
            tick_ff <= tick_ff + 32'h0000_0001;
    end

    // ======================================================================
    // Receive sequencer: bytes are buffered and only copied out once whole,
    // so a timeout mid-string leaves destination memory untouched
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff   <= S_IDLE;
            cnt_ff     <= 8'h00;
            ms_ff      <= 16'h0000;
            done_ff    <= 1'b0;
            ic_err_ff  <= 1'b0;
            fc_err_ff  <= 1'b0;
            cannot_ff  <= 1'b0;
            invalid_ff <= 1'b0;
        end
        else if (!enable)
        begin
            // Withdrawing enable clears complete and timeout flags
            state_ff   <= S_IDLE;
            cnt_ff     <= 8'h00;
            ms_ff      <= 16'h0000;
            done_ff    <= 1'b0;
            ic_err_ff  <= 1'b0;
            fc_err_ff  <= 1'b0;
            cannot_ff  <= 1'b0;
            invalid_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                begin
                    cannot_ff  <= no_exec;
                    invalid_ff <= len_bad;
                    if (!no_exec && !len_bad)
                        state_ff <= S_WAIT;
                    else
                        state_ff <= S_DONE;
                end
                S_WAIT:
                begin
                    if (rx_stb)
                    begin
                        buf_ff[0] <= dat_s2_ff;
                        cnt_ff    <= 8'h01;
                        ms_ff     <= 16'h0000;
                        // Single-byte string is whole at once
                        state_ff  <= (cfg_len == 8'h01) ? S_DONE : S_RECV;
                        done_ff   <= (cfg_len == 8'h01);
                    end
                    else if (ms_tick && fc_lim != 16'h0000)
                    begin
                        // Compare without the increment so a full-scale limit cannot wrap
                        if (ms_ff >= fc_lim)
                        begin
                            fc_err_ff <= 1'b1;
                            state_ff  <= S_DONE;
                        end
                        ms_ff <= ms_ff + 16'h0001;
                    end
                end
                S_RECV:
                begin
                    if (rx_stb)
                    begin
                        buf_ff[cnt_ff[6:0]] <= dat_s2_ff;
                        cnt_ff <= cnt_ff + 8'h01;
                        ms_ff  <= 16'h0000;  // Gap count restarts
                        if (cnt_ff + 8'h01 == cfg_len)
                        begin
                            done_ff  <= 1'b1;
                            state_ff <= S_DONE;
                        end
                    end
                    else if (ms_tick && ic_lim != 16'h0000)
                    begin
                        // Same wrap-free compare as the first-character limit
                        if (ms_ff >= ic_lim)
                        begin
                            ic_err_ff <= 1'b1;
                            state_ff  <= S_DONE;
                        end
                        ms_ff <= ms_ff + 16'h0001;
                    end
                end
                S_DONE:
                    state_ff <= S_DONE;  // Hold flags until enable drops
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Word writer: packs byte pairs into 16-bit words after completion
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_busy_ff <= 1'b0;
            wr_idx_ff  <= 8'h00;
            mem_we     <= 1'b0;
            mem_addr   <= 16'h0000;
            mem_wdata  <= 16'h0000;
        end
        else
        begin
            mem_we <= 1'b0;
            // Enable gates the start: a byte landing as enable drops must not write
            if (enable && (state_ff == S_RECV && rx_stb && cnt_ff + 8'h01 == cfg_len ||
                           state_ff == S_WAIT && rx_stb && cfg_len == 8'h01))
            begin
                wr_busy_ff <= 1'b1;
                wr_idx_ff  <= 8'h00;
            end
            else if (wr_busy_ff)
            begin
                mem_we   <= 1'b1;
                mem_addr <= cfg_dest + {9'h000, wr_idx_ff[7:1]};
                // Odd final byte pairs with zero in its partner half
                if (cfg_swap)
                    mem_wdata <= {buf_ff[wr_idx_ff[6:0]],
                                  (wr_idx_ff + 8'h01 < cfg_len) ? buf_ff[wr_idx_ff[6:0] + 7'd1] : 8'h00};
                else  // First byte low
                    mem_wdata <= {(wr_idx_ff + 8'h01 < cfg_len) ? buf_ff[wr_idx_ff[6:0] + 7'd1] : 8'h00,
                                  buf_ff[wr_idx_ff[6:0]]};
                wr_idx_ff <= wr_idx_ff + 8'h02;
                if (wr_idx_ff + 8'h02 >= cfg_len)
                    wr_busy_ff <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Port error flag: set wins over the clear by network command
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            comm_err_ff <= 1'b0;
        else if (err_s2_ff)
            comm_err_ff <= 1'b1;
        else if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_NETCMD])
            comm_err_ff <= 1'b0;
    end

    // ======================================================================
    // APB register writes; network command bit is self-clearing
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff     <= 3'b000;
            cfg_ff      <= 32'h0000_0000;
            tmo_ff      <= 32'h0000_0000;
            irq_mask_ff <= 5'b00000;
        end
        else
        begin
            ctrl_ff[`CTRL_NETCMD] <= 1'b0;
            if (apb_wr)
            begin
                case (paddr)
                    `REG_CTRL:     ctrl_ff     <= pwdata[2:0];
                    `REG_CFG:      cfg_ff      <= pwdata;
                    `REG_TIMEOUT:  tmo_ff      <= pwdata;
                    `REG_IRQ_MASK: irq_mask_ff <= pwdata[4:0];
                    default:       ;
                endcase
            end
        end
    end

    // ======================================================================
    // Sticky events, write one to clear; a new event wins over the clear
    wire [4:0] ev = {cannot_ff | invalid_ff, comm_err_ff, fc_err_ff, ic_err_ff, done_ff};
    reg  [4:0] ev_d_ff;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_d_ff     <= 5'b00000;
            irq_stat_ff <= 5'b00000;
            irq         <= 1'b0;
        end
        else
        begin
            ev_d_ff     <= ev;
            irq_stat_ff <= (irq_stat_ff & ~((apb_wr && paddr == `REG_IRQ_STAT) ? pwdata[4:0] : 5'b00000))
                           | (ev & ~ev_d_ff);
            irq         <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ======================================================================
    // Read data, registered in the setup phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (apb_rd)
        begin
            case (paddr)
                `REG_CTRL:     prdata <= {29'h0000_0000, ctrl_ff};
                `REG_CFG:      prdata <= cfg_ff;
                `REG_TIMEOUT:  prdata <= tmo_ff;
                // Port busy mirrors receive activity
                `REG_STATUS:   prdata <= {24'h00_0000, invalid_ff, cannot_ff, comm_err_ff, busy,
                                          fc_err_ff, ic_err_ff, done_ff, busy};
                `REG_IRQ_STAT: prdata <= {27'h000_0000, irq_stat_ff};
                `REG_IRQ_MASK: prdata <= {27'h000_0000, irq_mask_ff};
                `REG_COUNT:    prdata <= {24'h00_0000, cnt_ff};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// File: testbench/ascii_rx_monitor.sv
// Port-level assertions for the fixed-length ASCII receiver
`timescale 1ns/1ps
`include "ascii_rx_map.vh"

module ascii_rx_monitor
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        rx_valid,
    input wire        mem_we,
    input wire [15:0] mem_addr,
    input wire        irq
);
    reg [6:0] run_ff;
    reg       mzero_ff;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Helpers: write burst length, mask known to be all zero
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_ff   <= 7'h00;
            mzero_ff <= 1'b1;
        end
        else
        begin
            run_ff <= mem_we ? run_ff + 7'h01 : 7'h00;
            if (psel && penable && pwrite && paddr == `REG_IRQ_MASK)
                mzero_ff <= (pwdata[4:0] == 5'h00);
        end
    end

    // ==========================================================
    // Assertions
    a_words_consecutive: assert property (mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) + 16'h0001)
        else $error("word addresses not consecutive");
    a_burst_bounded: assert property (run_ff <= 7'h40)
        else $error("write burst longer than 64 words");
    a_write_after_byte: assert property ($rose(mem_we) |-> $past(rx_valid, 3))
        else $error("write burst without a recent byte");
    a_irq_masked_off: assert property (mzero_ff && $past(mzero_ff) && $past(mzero_ff, 2) |-> !irq)
        else $error("interrupt high with all events masked");
    a_irq_cleared: assert property (psel && penable && pwrite && paddr == `REG_IRQ_STAT
                                    && pwdata[4:0] == 5'h1F |-> ##2 !irq)
        else $error("interrupt still high after clearing all events");
    a_unmapped_zero: assert property (psel && penable && !pwrite && paddr == 12'h0FC |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_apb_zero_wait: assert property (psel && penable |-> pready && !pslverr)
        else $error("bus access not completed at once");
    a_reset_quiet: assert property ($rose(presetn) |-> !mem_we && !irq)
        else $error("outputs active right after reset");
endmodule

bind ascii_fixed_length_receiver ascii_rx_monitor i_ascii_rx_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .mem_we(mem_we), .mem_addr(mem_addr), .irq(irq));

// File: testbench/ascii_source.sv
// Behavioural serial ASCII source feeding byte strobes to the receiver
`timescale 1ns/1ps

module ascii_source
(
    input  wire       pclk,
    output reg        rx_valid,
    output reg  [7:0] rx_data,
    output reg        rx_error
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_error = 1'b0;
    end

    // Data set up one cycle ahead, strobe high 4 and low 4 cycles
    task send(input [7:0] b);
        begin
            rx_data <= b;
            @(posedge pclk);
            rx_valid <= 1'b1;
            repeat (4) @(posedge pclk);
            rx_valid <= 1'b0;
            rx_data  <= ~b;   // Hold time over: stale byte must not pass
            repeat (4) @(posedge pclk);
        end
    endtask

    // Line fault level, called just after a clock edge
    task fault(input lvl);
        rx_error <= lvl;
    endtask
endmodule

// File: testbench/tb_ascii_fixed_length_receiver.sv
// Self-checking bench for the fixed-length ASCII receiver
`timescale 1ns/1ps
`include "ascii_rx_map.vh"

module tb_ascii_fixed_length_receiver;
    reg         pclk;
    reg         presetn;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready;
    wire        rx_valid;
    wire [7:0]  rx_data;
    wire        rx_error;
    wire        mem_we;
    wire [15:0] mem_addr;
    wire [15:0] mem_wdata;
    wire        irq;
    reg  [15:0] mem [0:255];
    reg  [31:0] q;
    integer     n_mismatch;
    integer     compares;
    integer     n_wr;
    integer     cyc;
    integer     i;

    // Short millisecond keeps timeout runs brief
    ascii_fixed_length_receiver #(.MS_CYC(10)) i_ascii_fixed_length_receiver (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .irq(irq));
    ascii_source i_ascii_source (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Memory image, write count and hang limit
    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (mem_we === 1'b1)
        begin
            mem[mem_addr[7:0]] <= mem_wdata;
            n_wr = n_wr + 1;
        end
        if (cyc == 30000)
        begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end

    // ==========================================================
    // Tasks
    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // One APB transfer, entered and left just after a rising edge
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            q = prdata;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Register read; write data is a don't-care
    task rd(input [11:0] a);
        begin
            apb(1'b0, a, 32'h0000_0000);
        end
    endtask

    task start(input [31:0] cfg, input [31:0] to, input [31:0] ctrl);
        begin
            apb(1'b1, `REG_CTRL, 32'h0000_0000);
            apb(1'b1, `REG_CFG, cfg);
            apb(1'b1, `REG_TIMEOUT, to);
            apb(1'b1, `REG_CTRL, ctrl);
            n_wr = 0;
        end
    endtask

    // Polls status until a flag shows and busy has dropped, a bounded number of times
    task wait_st(input [31:0] m);
        begin
            q = 32'h0000_0000;
            for (i = 0; i < 100 && ((q & m) == 0 || q[`ST_BUSY]); i = i + 1)
                rd(`REG_STATUS);
        end
    endtask

    task finish_test;
        begin
            if (n_mismatch == 0 && compares > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        n_mismatch = 0;
        compares = 0;
        n_wr = 0;
        cyc = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`REG_STATUS);
        check(q, 32'h0000_0000);
        rd(12'h0FC);
        check(q, 32'h0000_0000);
        // Odd length: pad byte, busy while partial, sticky complete
        apb(1'b1, `REG_IRQ_MASK, 32'h0000_0001);
        start(32'h0040_2003, 32'h0000_0000, 32'h0000_0001);
        i_ascii_source.send(8'h41);
        rd(`REG_STATUS);
        check(q & 32'h0000_0011, 32'h0000_0011);
        i_ascii_source.send(8'h42);
        i_ascii_source.send(8'h43);
        wait_st(32'h0000_0002);
        check(q & 32'h0000_0013, 32'h0000_0002);
        check(mem[8'h40], 32'h0000_4241);
        check(mem[8'h41], 32'h0000_0043);
        check(n_wr, 32'h0000_0002);
        check(irq, 32'h0000_0001);
        apb(1'b1, `REG_IRQ_STAT, 32'h0000_001F);
        @(posedge pclk);
        check(irq, 32'h0000_0000);
        i_ascii_source.send(8'h44);
        check(n_wr, 32'h0000_0002);
        apb(1'b1, `REG_CTRL, 32'h0000_0000);
        rd(`REG_STATUS);
        check(q & 32'h0000_000F, 32'h0000_0000);
        // Swapped pair
        start(32'h0050_2102, 32'h0000_0000, 32'h0000_0001);
        i_ascii_source.send(8'h41);
        i_ascii_source.send(8'h42);
        wait_st(32'h0000_0002);
        check(mem[8'h50], 32'h0000_4142);
        // Longest string; nothing may be written before a byte arrives
        start(32'h0060_2080, 32'h0000_0000, 32'h0000_0001);
        repeat (5) @(posedge pclk);
        check(n_wr, 32'h0000_0000);
        for (i = 0; i < 128; i = i + 1)
            i_ascii_source.send(i[7:0]);
        wait_st(32'h0000_0002);
        check(n_wr, 32'h0000_0040);
        check(mem[8'h9F], 32'h0000_7F7E);
        rd(`REG_COUNT);
        check(q, 32'h0000_0080);
        // Gap timeout: flag, nothing stored, cleared on disable
        start(32'h0040_2004, 32'h0000_0002, 32'h0000_0001);
        i_ascii_source.send(8'h31);
        i_ascii_source.send(8'h32);
        repeat (60) @(posedge pclk);
        rd(`REG_STATUS);
        check(q & 32'h0000_000F, 32'h0000_0004);
        check(n_wr, 32'h0000_0000);
        // First character timeout, then both checks switched off
        start(32'h0040_2004, 32'h0002_0000, 32'h0000_0001);
        rd(`REG_STATUS);
        check(q & 32'h0000_000F, 32'h0000_0000);
        repeat (60) @(posedge pclk);
        rd(`REG_STATUS);
        check(q & 32'h0000_000F, 32'h0000_0008);
        start(32'h0040_2004, 32'h0000_0000, 32'h0000_0001);
        repeat (60) @(posedge pclk);
        rd(`REG_STATUS);
        check(q & 32'h0000_000F, 32'h0000_0000);
        // Refused setups: wrong port, bad lengths, transmit mode
        start(32'h0040_3004, 32'h0000_0000, 32'h0000_0001);
        rd(`REG_STATUS);
        check(q & 32'h0000_00C0, 32'h0000_0040);
        start(32'h0040_2000, 32'h0000_0000, 32'h0000_0001);
        rd(`REG_STATUS);
        check(q & 32'h0000_00C0, 32'h0000_0080);
        start(32'h0040_2081, 32'h0000_0000, 32'h0000_0001);
        rd(`REG_STATUS);
        check(q & 32'h0000_00C0, 32'h0000_0080);
        start(32'h0040_2004, 32'h0000_0000, 32'h0000_0005);
        rd(`REG_STATUS);
        check(q & 32'h0000_00C0, 32'h0000_0040);
        // Line fault, cleared by the network command bit
        i_ascii_source.fault(1'b1);
        repeat (5) @(posedge pclk);
        i_ascii_source.fault(1'b0);
        repeat (3) @(posedge pclk);
        rd(`REG_STATUS);
        check(q & 32'h0000_0020, 32'h0000_0020);
        apb(1'b1, `REG_CTRL, 32'h0000_0002);
        rd(`REG_STATUS);
        check(q & 32'h0000_0020, 32'h0000_0000);
        finish_test;
    end
endmodule
